// >>> src/wdrs_top.v
// Watchdog timer with reset-cause flags behind an APB register slave.
`timescale 1ns/1ps
`include "wdrs_defines.vh"

// Functional notes
// - Debug-port reset sets flag; POR or zero-write clears
// - Watchdog reset sets flag; POR or zero-write clears
// - Brown-out reset sets flag; POR or zero-write clears
// - Pin reset sets flag; POR or zero-write clears
// - Power-on sets flag; only zero-write clears it
// - Timeout in interrupt operation sets interrupt flag
// - Vector execution or one-write clears interrupt flag
// - Interrupt requested when global, enable, flag set
// - Enable bits select stopped/interrupt/reset/both modes
// - Vector in combined mode clears enable and flag
// - Unserviced interrupt in combined mode gives reset at next timeout
// - Programmed fuse forces system reset mode
// - Change enable self-clears after four clock cycles
// - Enable clear, prescaler change need change enable
// - Timer runs while enabled, stops when disabled
// - Watchdog reset flag forces enable bit high
// - Prescaler codes 0..9 give 2k to 1024k cycles
// - Timeout counted in 128 kHz oscillator ticks
// - Restart instruction restarts the watchdog counter
// - Reset-mode timeout gives one-cycle reset pulse
module wdrs_top #(
   parameter CLK_HZ = `WDRS_CLK_HZ,
   parameter OSC_HZ = `WDRS_OSC_HZ
) (
   input  wire        clk_i,
   input  wire        resetn_i,
   // APB slave.
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [11:0] paddr_i,
   input  wire [31:0] pwdata_i,
   output wire [31:0] prdata_o,
   output wire        pready_o,
   output wire        pslverr_o,
   // Processor side.
   input  wire        restart_i,
   input  wire        vector_ack_i,
   input  wire        global_int_en_i,
   output wire        timeout_irq_o,
   output wire        wdog_reset_o,
   // Reset sources and fuse from outside the clock domain.
   input  wire        always_on_fuse_i,
   input  wire        brownout_rst_i,
   input  wire        pin_rst_i,
   input  wire        debug_rst_i
);

   // Oscillator divider length, rounded down to whole system cycles.
   // The quotient is formed at full integer width and then cut to the
   // eight bits that the divider holds. A system clock faster than 256
   // oscillator periods would need a wider divider.
   localparam integer OSC_DIV_FULL = CLK_HZ / OSC_HZ;
   localparam [7:0]   OSC_DIV      = OSC_DIV_FULL[7:0];
   // Reset image of the cause flags, kept whole so it can be sliced.
   localparam [7:0]   RST_CAUSE    = `WDRS_RST_RESET_CAUSE;

   // Synchronisers for all asynchronous inputs, two stages each.
   reg  [3:0] sync1_r;
   reg  [3:0] sync2_r;
   wire       fuse_prog;
   wire       brownout_ev;
   wire       pin_ev;
   wire       debug_ev;

   always @(posedge clk_i or negedge resetn_i) begin
      // Both stages reset to the idle levels: fuse unprogrammed and no
      // source asserted. Any other value would fake a reset cause or a
      // programmed fuse in the first cycles after power-on.
      if (!resetn_i) begin
         sync1_r <= 4'h8;
         sync2_r <= 4'h8;
      end else begin
         sync1_r <= {always_on_fuse_i, brownout_rst_i, pin_rst_i,
                     debug_rst_i};
         sync2_r <= sync1_r;
      end
   end

   // The fuse reads zero when programmed; reset sources are high-active.
   assign fuse_prog   = ~sync2_r[3];
   assign brownout_ev = sync2_r[2];
   assign pin_ev      = sync2_r[1];
   assign debug_ev    = sync2_r[0];

   // Register layout and behaviour in brief.
   //
   // The reset cause register keeps one sticky flag per reset source.
   // Each flag is set by its source and cleared by writing a zero to
   // it; writing a one leaves the flag as it is. The power-on flag is
   // the only one that survives the block's own reset, because that
   // reset is the power-on event itself.
   //
   // The control register holds the interrupt flag, the interrupt
   // enable, the watchdog enable, the change enable and the four-bit
   // prescaler, whose top bit sits apart from the lower three.
   //
   // Mode selection follows the two enable bits: none stops the
   // counter, the interrupt enable alone gives interrupt mode, the
   // enable alone gives reset mode and both give the combined mode.
   // A programmed fuse overrides both bits and forces reset mode, so
   // a runaway program cannot switch the watchdog off.
   //
   // The change enable opens a short window in which the enable may be
   // cleared and the prescaler changed. Outside the window such writes
   // are ignored, which protects the watchdog from stray stores. The
   // window closes by itself after four system clock cycles, or at the
   // next control write that leaves the change enable bit low.
   //
   // The counter advances once per oscillator tick. The tick comes from
   // a divider of the system clock, so the timeout is exact in ticks
   // but the tick period is rounded to whole system cycles; software
   // that needs an exact time must allow for that rounding.
   //
   // A timeout in reset mode produces a one-cycle reset pulse and sets
   // the watchdog flag. While that flag is set the enable is pinned
   // high, so a failing program keeps being reset until it clears the
   // flag on purpose.
   //
   // Register state.
   reg  [4:0]  cause_r;
   reg  [4:0]  cause_nxt;
   reg         int_flag_r;
   reg         int_flag_nxt;
   reg         int_en_r;
   reg         int_en_nxt;
   reg         enable_r;
   reg         enable_nxt;
   reg         chg_en_r;
   reg         chg_en_nxt;
   reg  [2:0]  chg_cnt_r;
   reg  [2:0]  chg_cnt_nxt;
   reg  [3:0]  presc_r;
   reg  [3:0]  presc_nxt;
   reg  [31:0] prdata_r;
   reg  [7:0]  div_r;
   reg  [20:0] tick_cnt_r;
   reg         wdog_reset_r;

   // Bus decode; the slave answers every access without wait states.
   wire        setup     = psel_i & ~penable_i;
   wire        access    = psel_i & penable_i;
   wire        hit_cause = (paddr_i == `WDRS_ADDR_RESET_CAUSE);
   wire        hit_ctrl  = (paddr_i == `WDRS_ADDR_WDOG_CTRL);
   wire        wr_cause  = access & pwrite_i & hit_cause;
   wire        wr_ctrl   = access & pwrite_i & hit_ctrl;

   assign pready_o  = 1'b1;
   assign pslverr_o = access & ~hit_cause & ~hit_ctrl;
   assign prdata_o  = prdata_r;

   // Effective mode: the programmed fuse locks reset-only operation.
   wire eff_enable = enable_r | fuse_prog;
   wire eff_int_en = int_en_r & ~fuse_prog;
   wire running    = eff_enable | eff_int_en;

   // Timeout length; codes above nine behave as the longest setting.
   wire [3:0]  presc_eff = (presc_r > `WDRS_PRESC_MAX) ?
                           `WDRS_PRESC_MAX : presc_r;
   wire [20:0] limit     = `WDRS_BASE_TICKS << presc_eff;

   wire osc_tick = (div_r == OSC_DIV - 8'h01);
   wire timeout  = running & osc_tick &
                   (tick_cnt_r >= limit - 21'h000001);

   // Timeout action by mode. Interrupt-only mode sets the flag; reset
   // mode resets; the combined mode resets only when the earlier
   // interrupt is still pending.
   wire to_irq   = timeout & eff_int_en &
                   ~(eff_enable & int_flag_r);
   wire to_reset = timeout & eff_enable &
                   (~eff_int_en | int_flag_r);

   // Oscillator tick divider. It runs freely so ticks keep an even pace.
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         div_r <= 8'h00;
      end else if (osc_tick) begin
         div_r <= 8'h00;
      end else begin
         div_r <= div_r + 8'h01;
      end
   end

   // Timeout counter. A stopped watchdog holds it at zero so that a
   // later enable starts a full period.
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tick_cnt_r <= 21'h000000;
      end else if (!running || restart_i || timeout) begin
         tick_cnt_r <= 21'h000000;
      end else if (osc_tick) begin
         tick_cnt_r <= tick_cnt_r + 21'h000001;
      end
   end

   // Reset pulse of exactly one system clock cycle.
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wdog_reset_r <= 1'b0;
      end else begin
         wdog_reset_r <= to_reset;
      end
   end

   assign wdog_reset_o  = wdog_reset_r;
   assign timeout_irq_o = global_int_en_i & eff_int_en &
                          int_flag_r;

   // Reset-cause flags. A write may clear flags, but an event arriving
   // in the same cycle wins, so no cause is ever lost.
   always @* begin
      cause_nxt = cause_r;
      if (wr_cause) begin
         cause_nxt = cause_r & pwdata_i[4:0];
      end
      if (debug_ev) begin
         cause_nxt[`WDRS_BIT_DEBUG_PORT] = 1'b1;
      end
      if (to_reset) begin
         cause_nxt[`WDRS_BIT_WATCHDOG] = 1'b1;
      end
      if (brownout_ev) begin
         cause_nxt[`WDRS_BIT_BROWNOUT] = 1'b1;
      end
      if (pin_ev) begin
         cause_nxt[`WDRS_BIT_PIN_RESET] = 1'b1;
      end
   end

   // Control register. Enable may always be set but only cleared under
   // change enable; the prescaler follows the same guard.
   always @* begin
      int_flag_nxt = int_flag_r;
      int_en_nxt   = int_en_r;
      enable_nxt   = enable_r;
      chg_en_nxt   = chg_en_r;
      chg_cnt_nxt  = chg_cnt_r;
      presc_nxt    = presc_r;
      if (chg_en_r) begin
         chg_cnt_nxt = chg_cnt_r + 3'h1;
         if (chg_cnt_r == `WDRS_CHANGE_CYCLES - 3'h1) begin
            chg_en_nxt  = 1'b0;
            chg_cnt_nxt = 3'h0;
         end
      end
      if (wr_ctrl) begin
         if (pwdata_i[`WDRS_BIT_INT_FLAG]) begin
            int_flag_nxt = 1'b0;
         end
         int_en_nxt = pwdata_i[`WDRS_BIT_INT_ENABLE];
         if (pwdata_i[`WDRS_BIT_ENABLE]) begin
            enable_nxt = 1'b1;
         end else if (chg_en_r) begin
            enable_nxt = 1'b0;
         end
         if (chg_en_r) begin
            presc_nxt = {pwdata_i[`WDRS_BIT_PRESC3],
                         pwdata_i[`WDRS_BIT_PRESC2],
                         pwdata_i[`WDRS_BIT_PRESC1],
                         pwdata_i[`WDRS_BIT_PRESC0]};
         end
         if (pwdata_i[`WDRS_BIT_CHANGE_EN]) begin
            chg_en_nxt  = 1'b1;
            chg_cnt_nxt = 3'h0;
         end else begin
            chg_en_nxt  = 1'b0;
            chg_cnt_nxt = 3'h0;
         end
      end
      // Servicing the vector clears the flag; in the combined mode it
      // also drops the interrupt enable, leaving plain reset mode.
      if (vector_ack_i) begin
         int_flag_nxt = 1'b0;
         if (eff_enable) begin
            int_en_nxt = 1'b0;
         end
      end
      if (to_irq) begin
         int_flag_nxt = 1'b1;
      end
      // The watchdog reset flag pins enable high until it is cleared.
      // Looking at the next value too closes the one-cycle gap at the
      // edge where the flag is being set.
      if (cause_r[`WDRS_BIT_WATCHDOG] ||
          cause_nxt[`WDRS_BIT_WATCHDOG]) begin
         enable_nxt = 1'b1;
      end
   end

   // State registers. Power-on reset leaves only its own flag set.
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cause_r    <= RST_CAUSE[4:0];
         int_flag_r <= 1'b0;
         int_en_r   <= 1'b0;
         enable_r   <= 1'b0;
         chg_en_r   <= 1'b0;
         chg_cnt_r  <= 3'h0;
         presc_r    <= `WDRS_RST_PRESCALER;
      end else begin
         cause_r    <= cause_nxt;
         int_flag_r <= int_flag_nxt;
         int_en_r   <= int_en_nxt;
         enable_r   <= enable_nxt;
         chg_en_r   <= chg_en_nxt;
         chg_cnt_r  <= chg_cnt_nxt;
         presc_r    <= presc_nxt;
      end
   end

   // Read data is captured in the setup cycle and stands through the
   // access cycle. Reads show the effective, fuse-locked enable bits.
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prdata_r <= 32'h00000000;
      end else if (setup) begin
         if (hit_cause) begin
            prdata_r <= {27'h0000000, cause_r};
         end else if (hit_ctrl) begin
            prdata_r <= {24'h000000, int_flag_r, eff_int_en, presc_r[3],
                         chg_en_r, eff_enable, presc_r[2:0]};
         end else begin
            prdata_r <= 32'h00000000;
         end
      end
   end

endmodule // wdrs_top

// >>> src/wdrs_defines.vh
// Register map, field positions, reset values and timing for the watchdog.
`ifndef WDRS_DEFINES_VH
`define WDRS_DEFINES_VH

// Register byte addresses on the APB bus.
`define WDRS_ADDR_RESET_CAUSE      12'h054
`define WDRS_ADDR_WDOG_CTRL        12'h060

// Reset cause flag positions.
`define WDRS_BIT_POWER_ON          0
`define WDRS_BIT_PIN_RESET         1
`define WDRS_BIT_BROWNOUT          2
`define WDRS_BIT_WATCHDOG          3
`define WDRS_BIT_DEBUG_PORT        4

// Watchdog control and status field positions.
`define WDRS_BIT_PRESC0            0
`define WDRS_BIT_PRESC1            1
`define WDRS_BIT_PRESC2            2
`define WDRS_BIT_ENABLE            3
`define WDRS_BIT_CHANGE_EN         4
`define WDRS_BIT_PRESC3            5
`define WDRS_BIT_INT_ENABLE        6
`define WDRS_BIT_INT_FLAG          7

// Reset values.
`define WDRS_RST_RESET_CAUSE       8'h01
`define WDRS_RST_PRESCALER         4'h0

// Prescaler codes and the base timeout of the shortest setting.
`define WDRS_PRESC_MAX             4'h9
`define WDRS_BASE_TICKS            21'h000800

// Timing: system clock, oscillator rate and change window.
`define WDRS_CLK_HZ                25000000
`define WDRS_OSC_HZ                128000
`define WDRS_CHANGE_CYCLES         3'h4

`endif

// >>> testbench/wdrs_top_asserts.sv
// Concurrent checks on the port behaviour of the watchdog block.
`timescale 1ns/1ps
`include "wdrs_defines.vh"
module wdrs_chk (
   input wire        clk_i,
   input wire        resetn_i,
   input wire        psel_i,
   input wire        penable_i,
   input wire [11:0] paddr_i,
   input wire [31:0] prdata_o,
   input wire        pready_o,
   input wire        pslverr_o,
   input wire        vector_ack_i,
   input wire        global_int_en_i,
   input wire        timeout_irq_o,
   input wire        wdog_reset_o,
   input wire        always_on_fuse_i
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // Access phase and address decode; only two words are mapped.
   wire acc = psel_i && penable_i;
   wire hit = (paddr_i == `WDRS_ADDR_RESET_CAUSE) ||
              (paddr_i == `WDRS_ADDR_WDOG_CTRL);
   a_ready_high: assert property (pready_o)
      else $error("ready dropped");
   a_err_unmapped: assert property (acc && !hit |-> pslverr_o)
      else $error("no error on unmapped access");
   a_err_quiet: assert property (!(acc && !hit) |-> !pslverr_o)
      else $error("spurious error");
   a_upper_zero: assert property (acc |-> prdata_o[31:8] == 24'h0)
      else $error("upper read bits set");
   a_irq_gate: assert property (timeout_irq_o |-> global_int_en_i)
      else $error("irq without global enable");
   a_irq_drop: assert property
      ($fell(global_int_en_i) |-> !timeout_irq_o)
      else $error("irq outlives global enable");
   a_reset_pulse: assert property (wdog_reset_o |=> !wdog_reset_o)
      else $error("reset pulse too long");
   a_vector_clear: assert property (vector_ack_i |=> !timeout_irq_o)
      else $error("irq survives vector");
   // The fuse passes a two-stage synchroniser, hence three cycles.
   a_fuse_noirq: assert property
      (!always_on_fuse_i [*3] |-> !timeout_irq_o)
      else $error("irq while fuse programmed");
endmodule // wdrs_chk

bind wdrs_top wdrs_chk wdrs_chk_i (.clk_i(clk_i), .resetn_i(resetn_i),
   .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .vector_ack_i(vector_ack_i), .global_int_en_i(global_int_en_i),
   .timeout_irq_o(timeout_irq_o), .wdog_reset_o(wdog_reset_o),
   .always_on_fuse_i(always_on_fuse_i));

// >>> testbench/watchdog_reset_status_test.sv
// Directed register-level test of the watchdog and reset-cause block.
`timescale 1ns/1ps
`include "wdrs_defines.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
   $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module watchdog_reset_status_test;
   localparam [11:0] RC = `WDRS_ADDR_RESET_CAUSE;
   localparam [11:0] WC = `WDRS_ADDR_WDOG_CTRL;
   localparam int    TO = 2048 * 4; // Shortest timeout, divider of four.
   logic        clk_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0;
   logic        pwrite_i = 0, restart_i = 0, vector_ack_i = 0;
   logic        global_int_en_i = 0, always_on_fuse_i = 1;
   logic        brownout_rst_i = 0, pin_rst_i = 0, debug_rst_i = 0;
   logic [11:0] paddr_i = 0;
   logic [31:0] pwdata_i = 0, prdata_o, rdat;
   logic        pready_o, pslverr_o, timeout_irq_o, wdog_reset_o;
   int          n_fail = 0, checks = 0, n;
   // Faster oscillator keeps each timeout near eight thousand clocks.
   wdrs_top #(.OSC_HZ(`WDRS_CLK_HZ / 4)) wdrs_top_i (.clk_i(clk_i),
      .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .restart_i(restart_i), .vector_ack_i(vector_ack_i),
      .global_int_en_i(global_int_en_i), .timeout_irq_o(timeout_irq_o),
      .wdog_reset_o(wdog_reset_o), .always_on_fuse_i(always_on_fuse_i),
      .brownout_rst_i(brownout_rst_i), .pin_rst_i(pin_rst_i),
      .debug_rst_i(debug_rst_i));
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   // One APB transfer; the request holds until pready is seen high.
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
      @(posedge clk_i);
      psel_i    <= 1'b1;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= {24'h0, d};
      @(posedge clk_i);
      penable_i <= 1'b1;
      do @(posedge clk_i); while (pready_o !== 1'b1);
      rdat = prdata_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      xfer(1'b0, a, 8'h00);
      `CHK(rdat, {24'h0, e})
   endtask
   // One-cycle pulse of the vector acknowledge or the restart input.
   task automatic pulse(input logic ack);
      @(posedge clk_i);
      if (ack)
         vector_ack_i <= 1'b1;
      else
         restart_i <= 1'b1;
      @(posedge clk_i);
      {vector_ack_i, restart_i} <= 2'b00;
   endtask
   // Bounded wait for the reset pulse or the interrupt, counting clocks.
   // Outputs are looked at on the falling edge, where they have settled;
   // a wait that runs out counts as a mismatch.
   task automatic wait_ev(input logic rst);
      n = 0;
      while ((rst ? wdog_reset_o : timeout_irq_o) !== 1'b1 &&
             n < 3 * TO) begin
         @(negedge clk_i);
         n++;
      end
      if (n >= 3 * TO)
         n_fail++;
   endtask
   task automatic wrap_up;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Six timeouts plus register traffic fit well inside this span.
   initial begin
      repeat (90000) @(posedge clk_i);
      n_fail++;
      wrap_up;
   end
   initial begin
      repeat (10) @(posedge clk_i);
      resetn_i <= 1'b1;
      rd(RC, 8'h01);
      rd(WC, 8'h00);
      rd(12'h058, 8'h00);
      $display("test 1 done");
      @(posedge clk_i);
      {brownout_rst_i, pin_rst_i, debug_rst_i} <= 3'b111;
      @(posedge clk_i);
      {brownout_rst_i, pin_rst_i, debug_rst_i} <= 3'b000;
      repeat (4) @(posedge clk_i);
      rd(RC, 8'h17);
      wr(RC, 8'h01);
      rd(RC, 8'h01);
      wr(RC, 8'h00);
      rd(RC, 8'h00);
      $display("test 2 done");
      global_int_en_i <= 1'b1;
      pulse(1'b0);
      wr(WC, 8'h40);
      wait_ev(1'b0);
      `CHK(timeout_irq_o, 1'b1)
      rd(WC, 8'hc0);
      wr(WC, 8'hc0);
      rd(WC, 8'h40);
      wait_ev(1'b0);
      @(posedge clk_i);
      global_int_en_i <= 1'b0;
      @(posedge clk_i);
      `CHK(timeout_irq_o, 1'b0)
      global_int_en_i <= 1'b1;
      pulse(1'b1);
      rd(WC, 8'h40);
      wr(WC, 8'h00);
      rd(WC, 8'h00);
      $display("test 3 done");
      wr(WC, 8'h08);
      wr(WC, 8'h00);
      rd(WC, 8'h08);
      wr(WC, 8'h18);
      repeat (5) @(posedge clk_i);
      rd(WC, 8'h08);
      wr(WC, 8'h00);
      rd(WC, 8'h08);
      pulse(1'b0);
      wr(WC, 8'h18);
      wr(WC, 8'h23);
      rd(WC, 8'h23);
      wr(WC, 8'h18);
      wr(WC, 8'h00);
      rd(WC, 8'h00);
      $display("test 4 done");
      pulse(1'b0);
      wr(WC, 8'h08);
      repeat (6000) @(posedge clk_i);
      pulse(1'b0);
      wait_ev(1'b1);
      `CHK(wdog_reset_o, 1'b1)
      `CHK(n >= TO - 8 && n <= TO + 8, 1'b1)
      rd(RC, 8'h08);
      wr(WC, 8'h18);
      wr(WC, 8'h00);
      rd(WC, 8'h08);
      wr(RC, 8'h00);
      wr(WC, 8'h18);
      wr(WC, 8'h00);
      rd(WC, 8'h00);
      $display("test 5 done");
      pulse(1'b0);
      wr(WC, 8'h48);
      wait_ev(1'b0);
      rd(WC, 8'hc8);
      pulse(1'b1);
      rd(WC, 8'h08);
      wr(WC, 8'h48);
      wait_ev(1'b0);
      wait_ev(1'b1);
      `CHK(wdog_reset_o, 1'b1)
      wr(RC, 8'h00);
      wr(WC, 8'h98);
      wr(WC, 8'h00);
      rd(WC, 8'h00);
      $display("test 6 done");
      always_on_fuse_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      rd(WC, 8'h08);
      always_on_fuse_i <= 1'b1;
      $display("test 7 done");
      wrap_up;
   end
endmodule // watchdog_reset_status_test
